// *** design/dutc_params.svh ***
// Constants for the dual unchained timer with event capture.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef DUTC_PARAMS_SVH
`define DUTC_PARAMS_SVH
`define DUTC_ADDR_W        8
`define DUTC_OFF_COUNTER   8'h10
`define DUTC_OFF_PERIOD    8'h18
`define DUTC_OFF_TCTRL     8'h20
`define DUTC_OFF_GCTRL     8'h24
`define DUTC_OFF_RELOAD    8'h34
`define DUTC_OFF_CAPTURE   8'h3C
`define DUTC_SIDE_STRIDE   8'h04
`define DUTC_TC_SIDE_SHIFT 16
`define DUTC_TC_CAP_EN     3
`define DUTC_TC_EDGE_LSB   4
`define DUTC_TC_MODE_LSB   6
`define DUTC_TC_CLKSEL     8
`define DUTC_GC_RUN_A      0
`define DUTC_GC_RUN_B      1
`define DUTC_GC_ARR_LSB    2
`define DUTC_GC_EXT_ON     4
`define DUTC_GC_PSC_CNT    8
`define DUTC_GC_PSC_PER    12
`define DUTC_ARR_UNCHAINED 2'h1
`define DUTC_RESP_OKAY     2'h0
`define DUTC_RESP_SLVERR   2'h2
`endif

// *** design/dutc_pkg.sv ***
// Types for the dual unchained timer with event capture.
// Assumes dutc_params.svh is compiled alongside.
package dutc_pkg;
   typedef enum logic [1:0] {
      DUTC_MODE_OFF  = 2'h0,
      DUTC_MODE_ONCE = 2'h1,
      DUTC_MODE_CONT = 2'h2,
      DUTC_MODE_RELD = 2'h3
   } dutc_mode_t;
   typedef enum logic [1:0] {
      DUTC_EDGE_RISE = 2'h0,
      DUTC_EDGE_FALL = 2'h1,
      DUTC_EDGE_BOTH = 2'h2
   } dutc_edge_t;
endpackage : dutc_pkg

// *** design/dutc_timer.sv ***
// Dual 32-bit unchained timer with prescaler on side B and event capture.
// Assumes one clock, a synchronous active-low reset and an AXI4-Lite master.
//
// Overview of operation
// (RL1) Side A counts one per input clock.
// (RL2) Count equal to period pulses interrupt, DMA and pin.
// (RL3) Own run bit per side; zero holds reset.
// (RL4) Upper control half ignored by side A.
// (RL5) Mode 0 holds the count.
// (RL6) Mode 1 counts to period once, then stops.
// (RL7) Mode 2 clears the count after the period.
// (RL8) Mode 3 also reloads the period on wrap.
// (RL9) External clock: keep stopped timer off one period.
// (RL10) External clock edges are synchronized.
// (RL11) Count and period zero: count stays zero.
// (RL12) Sides are controlled independently.
// (RL13) Side A start order: arrangement, run, period, clock, mode.
// (RL14) Side B start order sets prescale period before mode.
// (RL15) Capture needs extended features and unchained mode.
// (RL16) Capture clears count, pulses, copies count; mode 3 also reloads period.
// (RL17) Capture needs internal clock and mode 2 or 3.
// (RL18) Each side has its own capture pin.
// (RL19) Capture edge select: rise, fall or both.
// (RL20) Prescaler pulses side B a cycle after its match.
// (RL21) Lower control half ignored by side B.
// (RL22) Side B prescaler clock is internal or external.
// (RL23) Counting needs arrangement field equal to one.
// (RL24) Pins pass two flip-flops; edges use previous sample.
// (RL25) Event outputs are one-cycle pulses.
`include "dutc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dutc_timer
   import dutc_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   input  wire logic                     clk_en,
   input  wire logic [`DUTC_ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [`DUTC_ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire logic                     capture_input_side_a,
   input  wire logic                     capture_input_side_b,
   input  wire logic                     ext_clock_side_a,
   input  wire logic                     ext_clock_side_b,
   output logic                          match_interrupt_a,
   output logic                          match_interrupt_b,
   output logic                          match_dma_request_a,
   output logic                          match_dma_request_b,
   output logic                          match_output_pin_a,
   output logic                          match_output_pin_b
);
   logic [31:0]             counter_r [2];
   logic [31:0]             period_r [2];
   logic [31:0]             reload_r [2];
   logic [31:0]             capture_r [2];
   logic                    done_r [2];
   logic                    irq_r [2];
   logic                    dma_r [2];
   logic                    pin_r [2];
   logic [31:0]             timer_control_r;
   logic [31:0]             global_control_r;
   logic [3:0]              prescale_count_r;
   logic                    prescale_pulse_r;
   logic [3:0]              sync1_r;
   logic [3:0]              sync2_r;
   logic [3:0]              prev_r;
   logic                    aw_got_r;
   logic                    w_got_r;
   logic [`DUTC_ADDR_W-1:0] waddr_r;
   logic [31:0]             wdata_r;
   logic [3:0]              wstrb_r;
   logic                    wr_fire;
   logic [31:0]             rd_val;
   logic                    rd_ok;
   logic [3:0]              rise_w;
   logic [3:0]              fall_w;
   logic                    tick_w [2];
   logic                    run_w [2];
   logic                    cap_hit_w [2];
   logic                    prescale_in_w;
   logic                    unchained_w;

   // Merges write data into an old value under the byte strobes.
   function automatic logic [31:0] dutc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            res[8*i +: 8] = new_v[8*i +: 8];
      return res;
   endfunction : dutc_merge

   // Pins are asynchronous, so only the second stage feeds edge logic.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
         prev_r  <= 4'h0;
      end
      else if (clk_en)
      begin
         sync1_r <= {ext_clock_side_b, ext_clock_side_a,
                     capture_input_side_b, capture_input_side_a}; // [RL18]
         sync2_r <= sync1_r;                                      // [RL24]
         prev_r  <= sync2_r;
      end
   end

   // Edges compare the synchronized sample against the previous one.
   assign rise_w = sync2_r & ~prev_r;                             // [RL24]
   assign fall_w = ~sync2_r & prev_r;
   assign unchained_w = global_control_r[`DUTC_GC_ARR_LSB +: 2]
                        == `DUTC_ARR_UNCHAINED;                   // [RL23]
   assign prescale_in_w =
      timer_control_r[`DUTC_TC_SIDE_SHIFT + `DUTC_TC_CLKSEL]
      ? rise_w[3] : 1'b1;                                         // [RL22] [RL10]
   assign tick_w[0] = timer_control_r[`DUTC_TC_CLKSEL]
                      ? rise_w[2] : 1'b1;                         // [RL1] [RL10]
   assign tick_w[1] = prescale_pulse_r;
   assign run_w[0]  = global_control_r[`DUTC_GC_RUN_A] & unchained_w; // [RL3]
   assign run_w[1]  = global_control_r[`DUTC_GC_RUN_B] & unchained_w; // [RL3]

   // Prescaler; the pulse lags the match by one cycle by construction.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         prescale_count_r <= 4'h0;
         prescale_pulse_r <= 1'b0;
      end
      else if (clk_en)
      begin
         prescale_pulse_r <= 1'b0;
         if (!run_w[1])
            prescale_count_r <= 4'h0;
         else if (prescale_in_w &&
                  timer_control_r[`DUTC_TC_SIDE_SHIFT + `DUTC_TC_MODE_LSB +: 2]
                  != DUTC_MODE_OFF)
         begin
            if (prescale_count_r ==
                global_control_r[`DUTC_GC_PSC_PER +: 4])
            begin
               prescale_pulse_r <= 1'b1;                          // [RL20]
               prescale_count_r <= 4'h0;
            end
            else
               prescale_count_r <= prescale_count_r + 4'h1;       // [RL20]
         end
         if (wr_fire && waddr_r == `DUTC_OFF_GCTRL && wstrb_r[1])
            prescale_count_r <= wdata_r[`DUTC_GC_PSC_CNT +: 4];
      end
   end

   // Each side reads only its own half of timer control.
   genvar gs;
   generate
      for (gs = 0; gs < 2; gs++)
      begin : g_side
         logic [15:0]            tc_w;
         dutc_mode_t             mode_w;
         logic                   evt_w;
         logic [`DUTC_ADDR_W-1:0] stride_w;
         assign tc_w   = timer_control_r[16*gs +: 16];            // [RL4] [RL21]
         assign mode_w = dutc_mode_t'(tc_w[`DUTC_TC_MODE_LSB +: 2]);
         assign stride_w = gs ? `DUTC_SIDE_STRIDE : 8'h00;
         always_comb
         begin
            case (dutc_edge_t'(tc_w[`DUTC_TC_EDGE_LSB +: 2]))     // [RL19]
               DUTC_EDGE_RISE: evt_w = rise_w[gs];
               DUTC_EDGE_FALL: evt_w = fall_w[gs];
               default:        evt_w = rise_w[gs] | fall_w[gs];
            endcase
         end
         assign cap_hit_w[gs] = evt_w && tc_w[`DUTC_TC_CAP_EN]
            && global_control_r[`DUTC_GC_EXT_ON]                  // [RL15]
            && !tc_w[`DUTC_TC_CLKSEL] && mode_w[1];               // [RL17]

         // Counting, matching and capture for one side.
         always_ff @(posedge clk)
         begin
            if (!reset_n)
            begin
               counter_r[gs] <= 32'h0;
               period_r[gs]  <= 32'h0;
               reload_r[gs]  <= 32'h0;
               capture_r[gs] <= 32'h0;
               done_r[gs]    <= 1'b0;
               irq_r[gs]     <= 1'b0;
               dma_r[gs]     <= 1'b0;
               pin_r[gs]     <= 1'b0;
            end
            else if (clk_en)
            begin
               irq_r[gs] <= 1'b0;                                 // [RL25]
               dma_r[gs] <= 1'b0;
               pin_r[gs] <= 1'b0;
               if (!run_w[gs])
               begin
                  counter_r[gs] <= 32'h0;                         // [RL3] [RL12]
                  done_r[gs]    <= 1'b0;
               end
               else if (cap_hit_w[gs] && run_w[gs])
               begin
                  counter_r[gs] <= 32'h0;                         // [RL16]
                  capture_r[gs] <= counter_r[gs];
                  irq_r[gs]     <= 1'b1;
                  dma_r[gs]     <= 1'b1;
                  pin_r[gs]     <= 1'b1;
                  if (mode_w == DUTC_MODE_RELD)
                     period_r[gs] <= reload_r[gs];
               end
               else if (mode_w == DUTC_MODE_OFF)
                  done_r[gs] <= 1'b0;                             // [RL5]
               else if (tick_w[gs] && !done_r[gs] &&
                        !(counter_r[gs] == 32'h0 &&
                          period_r[gs] == 32'h0))                 // [RL11]
               begin
                  if (counter_r[gs] == period_r[gs])
                  begin
                     irq_r[gs]     <= 1'b1;                       // [RL2]
                     dma_r[gs]     <= 1'b1;
                     pin_r[gs]     <= 1'b1;
                     capture_r[gs] <= counter_r[gs];
                     if (mode_w == DUTC_MODE_ONCE)
                        done_r[gs] <= 1'b1;                       // [RL6]
                     else
                        counter_r[gs] <= 32'h0;                   // [RL7]
                     if (mode_w == DUTC_MODE_RELD)
                        period_r[gs] <= reload_r[gs];             // [RL8]
                  end
                  else
                     counter_r[gs] <= counter_r[gs] + 32'h1;      // [RL1]
               end
               // A new mode lets a finished one-shot run again.
               if (mode_w != DUTC_MODE_ONCE)
                  done_r[gs] <= 1'b0;
               if (wr_fire && waddr_r == `DUTC_OFF_COUNTER + stride_w)
                  counter_r[gs] <= dutc_merge(counter_r[gs], wdata_r,
                                              wstrb_r);
               if (wr_fire && waddr_r == `DUTC_OFF_PERIOD + stride_w)
                  period_r[gs] <= dutc_merge(period_r[gs], wdata_r, wstrb_r);
               if (wr_fire && waddr_r == `DUTC_OFF_RELOAD + stride_w)
                  reload_r[gs] <= dutc_merge(reload_r[gs], wdata_r, wstrb_r);
            end
         end
      end
   endgenerate

   assign match_interrupt_a   = irq_r[0];
   assign match_interrupt_b   = irq_r[1];
   assign match_dma_request_a = dma_r[0];
   assign match_dma_request_b = dma_r[1];
   assign match_output_pin_a  = pin_r[0];
   assign match_output_pin_b  = pin_r[1];

   // Control registers; the prescale count field is live state instead.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         timer_control_r  <= 32'h0;
         global_control_r <= 32'h0;
      end
      else if (clk_en && wr_fire)
      begin
         if (waddr_r == `DUTC_OFF_TCTRL)
            timer_control_r <= dutc_merge(timer_control_r, wdata_r, wstrb_r);
         if (waddr_r == `DUTC_OFF_GCTRL)
            global_control_r <= dutc_merge(global_control_r, wdata_r,
                                           wstrb_r);
      end
   end

   // Address and data are latched separately so either may come first.
   assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         waddr_r       <= 8'h00;
         wdata_r       <= 32'h0;
         wstrb_r       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `DUTC_RESP_OKAY;
      end
      else if (clk_en)
      begin
         s_axi_awready <= !aw_got_r && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_got_r && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_r <= 1'b1;
            waddr_r  <= {s_axi_awaddr[`DUTC_ADDR_W-1:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (waddr_r[7:4] == 4'h1 || waddr_r == 8'h20 ||
                             waddr_r == 8'h24 || (waddr_r >= 8'h34 &&
                             waddr_r <= 8'h40))
                            ? `DUTC_RESP_OKAY : `DUTC_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read decode; unmapped words read zero with a slave error.
   always_comb
   begin
      rd_ok  = 1'b1;
      rd_val = 32'h0;
      case ({s_axi_araddr[`DUTC_ADDR_W-1:2], 2'h0})
         `DUTC_OFF_COUNTER:      rd_val = counter_r[0];
         `DUTC_OFF_COUNTER + 4:  rd_val = counter_r[1];
         `DUTC_OFF_PERIOD:       rd_val = period_r[0];
         `DUTC_OFF_PERIOD + 4:   rd_val = period_r[1];
         `DUTC_OFF_TCTRL:        rd_val = timer_control_r;
         `DUTC_OFF_GCTRL:        rd_val = {global_control_r[31:12],
                                           prescale_count_r,
                                           global_control_r[7:0]};
         `DUTC_OFF_RELOAD:       rd_val = reload_r[0];
         `DUTC_OFF_RELOAD + 4:   rd_val = reload_r[1];
         `DUTC_OFF_CAPTURE:      rd_val = capture_r[0];
         `DUTC_OFF_CAPTURE + 4:  rd_val = capture_r[1];
         default:                rd_ok  = 1'b0;
      endcase
   end

   // Read channel answers one cycle after the address is taken.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0;
         s_axi_rresp   <= `DUTC_RESP_OKAY;
      end
      else if (clk_en)
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? `DUTC_RESP_OKAY : `DUTC_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end
endmodule : dutc_timer
`default_nettype wire

// *** verification/dutc_timer_asserts.sv ***
// Checker for the dual timer: bus answer timing and event pulse shape.
// Assumes it is bound to dutc_timer and sees only that module's ports.
`include "dutc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dutc_timer_asserts
(
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        match_interrupt_a,
   input wire logic        match_interrupt_b,
   input wire logic        match_dma_request_a,
   input wire logic        match_dma_request_b,
   input wire logic        match_output_pin_a,
   input wire logic        match_output_pin_b
);
   // One clock domain, so clock and reset are shared.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // The three events of a side must leave together or software misses one.
   group_side_a_a: assert property (
      match_interrupt_a |-> match_dma_request_a && match_output_pin_a)
      else $error("side a events split");
   group_side_b_a: assert property (
      match_interrupt_b |-> match_dma_request_b && match_output_pin_b)
      else $error("side b events split");
   pulse_once_a_a: assert property (
      match_interrupt_a |=> !match_interrupt_a)
      else $error("side a pulse longer than one cycle");
   pulse_once_b_a: assert property (
      match_interrupt_b |=> !match_interrupt_b)
      else $error("side b pulse longer than one cycle");
   reset_quiet_a: assert property (
      $rose(reset_n) |-> !match_interrupt_a && !match_interrupt_b
      && !s_axi_bvalid) else $error("busy after reset");
   // Bus answers must stand until taken, and come in the stated time.
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write answer late");
   write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready &&
      !s_axi_wready) else $error("write taken while answer pending");

   cover property (match_interrupt_a);
   cover property (match_interrupt_b);
   cover property (s_axi_bvalid && s_axi_bresp == `DUTC_RESP_SLVERR);
endmodule : dutc_timer_asserts

bind dutc_timer dutc_timer_asserts i_chk (.*);
`default_nettype wire

// *** verification/dutc_timer_tb.sv ***
// Self-checking bench for the dual timer, driven over AXI4-Lite.
// Assumes dutc_timer, its package and the bound checker are compiled first.
`include "dutc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module dutc_timer_tb
   import dutc_pkg::*;
;
   localparam logic [7:0]  CNT_A = `DUTC_OFF_COUNTER;
   localparam logic [7:0]  CNT_B = `DUTC_OFF_COUNTER + `DUTC_SIDE_STRIDE;
   localparam logic [7:0]  PER_A = `DUTC_OFF_PERIOD;
   localparam logic [7:0]  PER_B = `DUTC_OFF_PERIOD + `DUTC_SIDE_STRIDE;
   localparam logic [7:0]  TCTL  = `DUTC_OFF_TCTRL;
   localparam logic [7:0]  GCTL  = `DUTC_OFF_GCTRL;
   localparam logic [7:0]  REL_A = `DUTC_OFF_RELOAD;
   localparam logic [7:0]  CAP_A = `DUTC_OFF_CAPTURE;
   localparam logic [31:0] ARR   = 32'(`DUTC_ARR_UNCHAINED) << `DUTC_GC_ARR_LSB;
   localparam logic [31:0] RUN_A = 32'h1 << `DUTC_GC_RUN_A;
   localparam logic [31:0] RUN_B = 32'h1 << `DUTC_GC_RUN_B;
   localparam logic [31:0] EXT   = 32'h1 << `DUTC_GC_EXT_ON;
   localparam logic [31:0] PSC3  = 32'h3 << `DUTC_GC_PSC_PER;
   localparam logic [1:0]  OK    = `DUTC_RESP_OKAY;
   localparam logic [1:0]  ERR   = `DUTC_RESP_SLVERR;

   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic        cap_a = 1'b0, cap_b = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        irq_a, irq_b;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [31:0] rnd = 32'hD4DB;
   logic [33:0] notes[$];
   int          n_fail = 0, n_checks = 0, cyc = 0, cnt_a = 0, cnt_b = 0;
   int          a0, b0;

   // Free-running clock at 125 MHz.
   always #4 clk = ~clk;

   dutc_timer i_dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(s_axi_rready),
      .capture_input_side_a(cap_a), .capture_input_side_b(cap_b),
      .ext_clock_side_a(1'b0), .ext_clock_side_b(1'b0),
      .match_interrupt_a(irq_a), .match_interrupt_b(irq_b),
      .match_dma_request_a(), .match_dma_request_b(),
      .match_output_pin_a(), .match_output_pin_b());

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next

   // One half of timer_control; the caller places it in the side's half.
   function automatic logic [15:0] half(input dutc_mode_t m, input logic cap,
                                        input logic [1:0] e, input logic ck);
      return 16'(m) << `DUTC_TC_MODE_LSB | 16'(cap) << `DUTC_TC_CAP_EN
           | 16'(e) << `DUTC_TC_EDGE_LSB | 16'(ck) << `DUTC_TC_CLKSEL;
   endfunction : half

   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : tally_and_finish

   // Address and data go out together; each drops when taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r = OK);
      bit ta = 0;
      bit tw = 0;
      notes.push_back({r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw))
      begin
         @(posedge clk);
         if (s_axi_awvalid && awready) ta = 1'b1;
         if (s_axi_wvalid && wready) tw = 1'b1;
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r = OK);
      notes.push_back({r, d});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask : rd

   // Toggle one capture pin; count pulses on both sides.
   task automatic toggle(input bit on_b, input int ea, input int eb);
      a0 = cnt_a;
      b0 = cnt_b;
      @(posedge clk);
      if (on_b) cap_b <= !cap_b;
      else cap_a <= !cap_a;
      repeat (8) @(posedge clk);
      check(34'(cnt_a - a0), 34'(ea));
      check(34'(cnt_b - b0), 34'(eb));
   endtask : toggle

   // Monitor: each bus answer meets the oldest note.
   always @(posedge clk)
   begin
      if (bvalid === 1'b1 && s_axi_bready) check({bresp, 32'h0}, notes.pop_front());
      if (rvalid === 1'b1 && s_axi_rready) check({rresp, rdata}, notes.pop_front());
      if (irq_a === 1'b1) cnt_a <= cnt_a + 1;
      if (irq_b === 1'b1) cnt_b <= cnt_b + 1;
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end

   initial
   begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rnd = lfsr_next(rnd);
      wr(PER_A, rnd);
      rd(PER_A, rnd);
      rd(GCTL, 32'h0);
      wr(8'h80, rnd, ERR);
      rd(8'h80, 32'h0, ERR);
      wr(CAP_A, rnd);
      rd(CAP_A, 32'h0);
      $display("test registers done");
      wr(GCTL, ARR | RUN_A);
      wr(PER_A, 32'd20);
      a0 = cnt_a;
      wr(TCTL, {half(DUTC_MODE_CONT, 0, 0, 0), half(DUTC_MODE_ONCE, 0, 0, 0)});
      repeat (40) @(posedge clk);
      rd(CNT_A, 32'd20);
      rd(CNT_B, 32'h0);
      check(34'(cnt_a - a0), 34'd1);
      $display("test one-shot done");
      wr(TCTL, {half(DUTC_MODE_CONT, 0, 0, 0), 16'h0});
      wr(CNT_A, rnd);
      repeat (20) @(posedge clk);
      rd(CNT_A, rnd);
      $display("test hold done");
      wr(GCTL, ARR | RUN_A | RUN_B | PSC3);
      wr(TCTL, 32'h0);
      wr(CNT_A, 32'h0);
      wr(CNT_B, 32'h0);
      wr(PER_A, 32'd9);
      wr(PER_B, 32'd4);
      {a0, b0} = {cnt_a, cnt_b};
      wr(TCTL, {half(DUTC_MODE_CONT, 0, 0, 0), half(DUTC_MODE_CONT, 0, 0, 0)});
      repeat (200) @(posedge clk);
      check(34'(cnt_a - a0 inside {[19:21]}), 34'h1);
      check(34'(cnt_b - b0 inside {[9:11]}), 34'h1);
      $display("test continuous done");
      wr(TCTL, 32'h0);
      wr(CNT_A, 32'h0);
      wr(PER_A, 32'd4);
      wr(REL_A, 32'd9);
      wr(TCTL, {16'h0, half(DUTC_MODE_RELD, 0, 0, 0)});
      repeat (30) @(posedge clk);
      rd(PER_A, 32'd9);
      wr(TCTL, 32'h0);
      wr(CNT_A, 32'h0);
      wr(PER_A, 32'h0);
      a0 = cnt_a;
      wr(TCTL, {16'h0, half(DUTC_MODE_CONT, 0, 0, 0)});
      repeat (20) @(posedge clk);
      rd(CNT_A, 32'h0);
      check(34'(cnt_a - a0), 34'h0);
      $display("test reload and zero done");
      wr(GCTL, ARR | RUN_A | RUN_B | EXT);
      wr(TCTL, 32'h0);
      wr(PER_A, 32'hFFFF);
      wr(PER_B, 32'hFFFF);
      wr(CNT_A, 32'h0);
      wr(CNT_B, 32'h0);
      for (int e = 0; e < 3; e++)
      begin
         wr(TCTL, {16'h0, half(DUTC_MODE_CONT, 1, 2'(e), 0)});
         for (int r = 0; r < 2; r++)
            toggle(0, (e == 2 || e == r) ? 1 : 0, 0);
      end
      wr(TCTL, {half(DUTC_MODE_CONT, 1, 2, 0), half(DUTC_MODE_CONT, 1, 2, 0)});
      toggle(1, 0, 1);
      toggle(0, 1, 0);
      wr(TCTL, {16'h0, half(DUTC_MODE_CONT, 1, 2, 1)});
      toggle(0, 0, 0);
      wr(TCTL, {16'h0, half(DUTC_MODE_ONCE, 1, 2, 0)});
      toggle(0, 0, 0);
      wr(GCTL, ARR | RUN_A | RUN_B);
      wr(TCTL, {16'h0, half(DUTC_MODE_CONT, 1, 2, 0)});
      toggle(0, 0, 0);
      $display("test capture done");
      tally_and_finish();
   end
endmodule : dutc_timer_tb
`default_nettype wire
